// *** psch_defines.vh ***
/*
  Constants of the periodic interrupt scheduler: register offsets, field
  positions, reset values and timing figures. Assumes a 100 MHz core clock
  and a 32-bit APB register bus with byte addresses.
*/
// Behaviour
// - Periodic interrupt every 10 to 140 ms.
// - Periodic interrupt jumps to its vector label.
// - Handler end resumes at interrupted address.
// - All sources enabled by default, individually maskable.
// - Periodic enabled flag follows mask state.
// - Fourth nested call raises execution error.
// - Five vectors: four inputs, then periodic.
// - Priority a, b, c, periodic, d.
// - No preemption; requests wait for handler end.
// - Periodic handler over 670 us is error.
// - About 60 us from event to handler.
// - Configuration applies only on program load.
// - Input edge selectable: rising, falling, both.
`ifndef PSCH_DEFINES_VH
`define PSCH_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PSCH_REG_CTRL 8'h00
`define PSCH_REG_EDGE 8'h04
`define PSCH_REG_VEC0 8'h08
`define PSCH_REG_VEC4 8'h18
`define PSCH_REG_STATE 8'h1c
`define PSCH_REG_ISTAT 8'h20
`define PSCH_REG_IMASK 8'h24

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define PSCH_CTRL_EN_BIT 0
`define PSCH_CTRL_IVL_LSB 8
`define PSCH_CTRL_IVL_MSB 15
`define PSCH_CTRL_RST 32'h00000a00
`define PSCH_EDGE_RST 8'h55
`define PSCH_EDGE_RISE 2'h1
`define PSCH_EDGE_FALL 2'h2
`define PSCH_IVL_MIN 8'h0a
`define PSCH_IVL_MAX 8'h8c
`define PSCH_NEST_MAX 2'h3
`define PSCH_EV_ERR 0
`define PSCH_EV_START 1
`define PSCH_EV_TICK 2
`define PSCH_NUM_EV 3
`define PSCH_SRC_PERIODIC 3'h4

// ****************************************************************
// Timing
// ****************************************************************
`define PSCH_CLK_NS 10
`define PSCH_MS_NS 1000000
`define PSCH_LATENCY_NS 60000
`define PSCH_HANDLER_MAX_NS 670000

`endif

// *** psch_edge_det.v ***
/*
  Synchroniser and selectable edge detector for the external interrupt
  lines. Assumes asynchronous pin inputs and the core clock.
*/
`timescale 1ns/1ps
`include "psch_defines.vh"

module psch_edge_det #(
  parameter N = 4
)(
  input wire core_clk,
  input wire resetn,
  input wire [N-1:0] line_in,
  input wire [2*N-1:0] edge_sel,
  output wire [N-1:0] event_pulse
);

  reg [N-1:0] meta_ff;
  reg [N-1:0] sync_ff;
  reg [N-1:0] prev_ff;
  reg [N-1:0] nxt_event;
  integer i;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= {N{1'b0}};
      sync_ff <= {N{1'b0}};
      prev_ff <= {N{1'b0}};
    end
    else
    begin
      meta_ff <= line_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // A line may ask for either edge or both.
  always @*
  begin
    for (i = 0; i < N; i = i + 1)
    begin
      nxt_event[i] = (edge_sel[2*i] & sync_ff[i] & ~prev_ff[i]) |
                     (edge_sel[2*i+1] & ~sync_ff[i] & prev_ff[i]);
    end
  end

  assign event_pulse = nxt_event;

endmodule

// *** psch_top.v ***
/*
  Periodic interrupt scheduler: interval timer, four external interrupt
  lines, fixed-priority dispatch without preemption, return address,
  nesting and run-time checks, APB register file and interrupt output.
  Assumes the CPU core pulses its op strobes for one core_clk cycle and
  holds cpu_pc at the address of the next instruction to run.
*/
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "psch_defines.vh"

module psch_top #(
  parameter AW = 16,
  parameter LW = 16,
  parameter MS_CYCLES = `PSCH_MS_NS / `PSCH_CLK_NS,
  parameter LAT_CYCLES = (`PSCH_LATENCY_NS + `PSCH_CLK_NS - 1) / `PSCH_CLK_NS,
  parameter RUN_MAX_CYCLES = `PSCH_HANDLER_MAX_NS / `PSCH_CLK_NS
)(
  input wire core_clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [3:0] ext_irq_line,
  input wire cpu_running,
  input wire prog_load,
  input wire [AW-1:0] cpu_pc,
  input wire irq_mask_op,
  input wire irq_unmask_op,
  input wire [2:0] op_src,
  input wire call_op,
  input wire handler_return_op,
  output reg jump_ff,
  output reg [LW-1:0] jump_label_ff,
  output reg resume_ff,
  output reg [AW-1:0] resume_addr_ff,
  output reg in_handler_ff,
  output reg periodic_irq_enabled_flag,
  output reg program_exec_error_flag,
  output reg err_led_ff,
  output reg irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam [19:0] LAT_LOAD = LAT_CYCLES - 1;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [31:0] ctrl_ff;
  reg [7:0] edge_ff;
  reg [LW-1:0] vec_ff [0:4];
  reg [`PSCH_NUM_EV-1:0] istat_ff;
  reg [`PSCH_NUM_EV-1:0] imask_ff;
  // Live copies applied only when a program is loaded.
  reg live_en_ff;
  reg [7:0] live_ivl_ff;
  reg [7:0] live_edge_ff;

  reg [4:0] enable_ff;
  reg [4:0] pend_ff;
  reg [1:0] state_ff;
  reg [2:0] src_ff;
  reg [AW-1:0] saved_pc_ff;
  reg [1:0] depth_ff;
  reg [19:0] lat_cnt_ff;
  reg [19:0] run_cnt_ff;
  reg [19:0] ms_cnt_ff;
  reg [7:0] ivl_cnt_ff;
  reg ms_tick_ff;

  wire [3:0] ext_event;
  wire apb_acc = psel & penable & ~pready;
  // Writes land at the completing edge, when pready is seen high.
  wire apb_wr = psel & penable & pready & pwrite;
  wire apb_rd = apb_acc & ~pwrite;
  reg [`PSCH_NUM_EV-1:0] nxt_ev;
  reg periodic_expire;
  reg [2:0] win_src;
  reg win_valid;
  reg [31:0] nxt_rdata;
  reg nxt_err;
  integer k;

  // Clamp an interval to the supported range of whole milliseconds.
  function [7:0] clamp_ivl;
    input [7:0] v;
    begin
      if (v < `PSCH_IVL_MIN)
        clamp_ivl = `PSCH_IVL_MIN;
      else if (v > `PSCH_IVL_MAX)
        clamp_ivl = `PSCH_IVL_MAX;
      else
        clamp_ivl = v;
    end
  endfunction

  // Map a byte address in the vector range to its slot.
  function [2:0] vec_slot;
    input [7:0] a;
    reg [7:0] d;
    begin
      d = a - `PSCH_REG_VEC0;
      vec_slot = d[4:2];
    end
  endfunction

  psch_edge_det #(
    .N(4)
  ) u_edge (
    .core_clk(core_clk),
    .resetn(resetn),
    .line_in(ext_irq_line),
    .edge_sel(live_edge_ff),
    .event_pulse(ext_event)
  );

  // ****************************************************************
  // APB register access
  // ****************************************************************
  wire vec_hit = (paddr >= `PSCH_REG_VEC0) && (paddr <= `PSCH_REG_VEC4) &&
                 (paddr[1:0] == 2'h0);

  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    if (vec_hit)
      nxt_rdata[LW-1:0] = vec_ff[vec_slot(paddr)];
    else
    begin
      case (paddr)
        `PSCH_REG_CTRL: nxt_rdata = ctrl_ff;
        `PSCH_REG_EDGE: nxt_rdata[7:0] = edge_ff;
        `PSCH_REG_STATE: nxt_rdata = {20'h00000, depth_ff, src_ff, state_ff,
                                      enable_ff};
        `PSCH_REG_ISTAT: nxt_rdata[`PSCH_NUM_EV-1:0] = istat_ff;
        `PSCH_REG_IMASK: nxt_rdata[`PSCH_NUM_EV-1:0] = imask_ff;
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // One wait state: the access phase ends on the second edge.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_ff <= `PSCH_CTRL_RST;
      edge_ff <= `PSCH_EDGE_RST;
      imask_ff <= {`PSCH_NUM_EV{1'b0}};
      for (k = 0; k < 5; k = k + 1)
        vec_ff[k] <= {LW{1'b0}};
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & nxt_err;
      if (apb_rd)
        prdata <= nxt_rdata;
      if (apb_wr && !nxt_err)
      begin
        if (vec_hit)
          vec_ff[vec_slot(paddr)] <= pwdata[LW-1:0];
        else
        begin
          case (paddr)
            `PSCH_REG_CTRL: ctrl_ff <= pwdata;
            `PSCH_REG_EDGE: edge_ff <= pwdata[7:0];
            `PSCH_REG_IMASK: imask_ff <= pwdata[`PSCH_NUM_EV-1:0];
            default: ctrl_ff <= ctrl_ff;
          endcase
        end
      end
    end
  end

  // Sticky events; a new event wins over a write-one-to-clear.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      istat_ff <= {`PSCH_NUM_EV{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == `PSCH_REG_ISTAT)
        istat_ff <= (istat_ff & ~pwdata[`PSCH_NUM_EV-1:0]) | nxt_ev;
      else
        istat_ff <= istat_ff | nxt_ev;
      irq <= |(istat_ff & imask_ff);
    end
  end

  // ****************************************************************
  // Configuration and masks
  // ****************************************************************
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      live_en_ff <= 1'b0;
      live_ivl_ff <= `PSCH_IVL_MIN;
      live_edge_ff <= `PSCH_EDGE_RST;
      enable_ff <= 5'h1f;
    end
    else
    begin
      if (prog_load)
      begin
        live_en_ff <= ctrl_ff[`PSCH_CTRL_EN_BIT];
        live_ivl_ff <= clamp_ivl(ctrl_ff[`PSCH_CTRL_IVL_MSB:`PSCH_CTRL_IVL_LSB]);
        live_edge_ff <= edge_ff;
        enable_ff <= 5'h1f;
      end
      else if (irq_mask_op && op_src <= `PSCH_SRC_PERIODIC)
        enable_ff[op_src] <= 1'b0;
      else if (irq_unmask_op && op_src <= `PSCH_SRC_PERIODIC)
        enable_ff[op_src] <= 1'b1;
    end
  end

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  // The interval counter never waits for a handler, so a late dispatch
  // does not stretch the following period.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ms_cnt_ff <= 20'h00000;
      ms_tick_ff <= 1'b0;
      ivl_cnt_ff <= 8'h00;
    end
    else if (!cpu_running || !live_en_ff || prog_load)
    begin
      ms_cnt_ff <= 20'h00000;
      ms_tick_ff <= 1'b0;
      ivl_cnt_ff <= 8'h00;
    end
    else
    begin
      ms_tick_ff <= (ms_cnt_ff == MS_CYCLES - 1);
      if (ms_cnt_ff == MS_CYCLES - 1)
        ms_cnt_ff <= 20'h00000;
      else
        ms_cnt_ff <= ms_cnt_ff + 20'h00001;
      if (ms_tick_ff)
      begin
        if (ivl_cnt_ff == live_ivl_ff - 8'h01)
          ivl_cnt_ff <= 8'h00;
        else
          ivl_cnt_ff <= ivl_cnt_ff + 8'h01;
      end
    end
  end

  always @*
  begin
    periodic_expire = ms_tick_ff && (ivl_cnt_ff == live_ivl_ff - 8'h01);
  end

  // ****************************************************************
  // Pending requests and arbitration
  // ****************************************************************
  // Slots 0..3 are the external lines, slot 4 is the periodic timer.
  always @*
  begin
    win_valid = 1'b1;
    if (pend_ff[0])
      win_src = 3'h0;
    else if (pend_ff[1])
      win_src = 3'h1;
    else if (pend_ff[2])
      win_src = 3'h2;
    else if (pend_ff[4])
      win_src = `PSCH_SRC_PERIODIC;
    else if (pend_ff[3])
      win_src = 3'h3;
    else
    begin
      win_src = 3'h0;
      win_valid = 1'b0;
    end
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pend_ff <= 5'h00;
    else if (!cpu_running || prog_load)
      pend_ff <= 5'h00;
    else
    begin
      // Requests keep accumulating while a handler runs.
      pend_ff <= (pend_ff & enable_ff &
                  ~((state_ff == ST_IDLE && win_valid) ? (5'h01 << win_src) : 5'h00))
                 | ({periodic_expire, ext_event} & enable_ff);
    end
  end

  // ****************************************************************
  // Dispatch, handler tracking and checks
  // ****************************************************************
  always @*
  begin
    nxt_ev = {`PSCH_NUM_EV{1'b0}};
    nxt_ev[`PSCH_EV_TICK] = periodic_expire;
    nxt_ev[`PSCH_EV_START] = (state_ff == ST_WAIT) && (lat_cnt_ff == 20'h00000) &&
                             cpu_running;
    nxt_ev[`PSCH_EV_ERR] = (state_ff == ST_RUN) &&
                           ((call_op && depth_ff == `PSCH_NEST_MAX) ||
                            (src_ff == `PSCH_SRC_PERIODIC &&
                             run_cnt_ff == RUN_MAX_CYCLES));
  end

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= ST_IDLE;
      src_ff <= 3'h0;
      saved_pc_ff <= {AW{1'b0}};
      depth_ff <= 2'h0;
      lat_cnt_ff <= 20'h00000;
      run_cnt_ff <= 20'h00000;
      jump_ff <= 1'b0;
      jump_label_ff <= {LW{1'b0}};
      resume_ff <= 1'b0;
      resume_addr_ff <= {AW{1'b0}};
      in_handler_ff <= 1'b0;
    end
    else
    begin
      jump_ff <= 1'b0;
      resume_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (cpu_running && win_valid && !prog_load)
          begin
            state_ff <= ST_WAIT;
            src_ff <= win_src;
            lat_cnt_ff <= LAT_LOAD;
          end
        end
        ST_WAIT:
        begin
          // A stop while waiting abandons the dispatch, so no handler is left open.
          if (!cpu_running)
            state_ff <= ST_IDLE;
          else if (lat_cnt_ff == 20'h00000)
          begin
            state_ff <= ST_RUN;
            saved_pc_ff <= cpu_pc;
            jump_ff <= 1'b1;
            jump_label_ff <= vec_ff[src_ff];
            in_handler_ff <= 1'b1;
            depth_ff <= 2'h0;
            run_cnt_ff <= 20'h00000;
          end
          else
            lat_cnt_ff <= lat_cnt_ff - 20'h00001;
        end
        ST_RUN:
        begin
          if (run_cnt_ff != RUN_MAX_CYCLES)
            run_cnt_ff <= run_cnt_ff + 20'h00001;
          if (call_op && depth_ff != `PSCH_NEST_MAX)
            depth_ff <= depth_ff + 2'h1;
          else if (handler_return_op && depth_ff != 2'h0)
            depth_ff <= depth_ff - 2'h1;
          else if (handler_return_op)
          begin
            state_ff <= ST_IDLE;
            resume_ff <= 1'b1;
            resume_addr_ff <= saved_pc_ff;
            in_handler_ff <= 1'b0;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      if (!cpu_running && state_ff != ST_RUN)
        state_ff <= ST_IDLE;
    end
  end

  // Error stays until the next program load.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      program_exec_error_flag <= 1'b0;
      err_led_ff <= 1'b0;
      periodic_irq_enabled_flag <= 1'b0;
    end
    else
    begin
      if (nxt_ev[`PSCH_EV_ERR])
      begin
        program_exec_error_flag <= 1'b1;
        err_led_ff <= 1'b1;
      end
      else if (prog_load)
      begin
        program_exec_error_flag <= 1'b0;
        err_led_ff <= 1'b0;
      end
      periodic_irq_enabled_flag <= live_en_ff & cpu_running &
                                   enable_ff[`PSCH_SRC_PERIODIC];
    end
  end

endmodule

// *** psch_checker.sv ***
/*
  Port checker for psch_top.
  Assumes one core clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module psch_checker (
  input wire core_clk,
  input wire resetn,
  input wire pready,
  input wire prog_load,
  input wire call_op,
  input wire handler_return_op,
  input wire irq_mask_op,
  input wire [2:0] op_src,
  input wire jump_ff,
  input wire resume_ff,
  input wire in_handler_ff,
  input wire periodic_irq_enabled_flag,
  input wire program_exec_error_flag,
  input wire err_led_ff
);
  // ****************************************************************
  // Call depth, rebuilt here because the design does not export it.
  // ****************************************************************
  reg [1:0] dep_ff;
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
      dep_ff <= 2'h0;
    else if (jump_ff)
      dep_ff <= 2'h0;
    else if (call_op && dep_ff != 2'h3)
      dep_ff <= dep_ff + 2'h1;
    else if (handler_return_op && dep_ff != 2'h0)
      dep_ff <= dep_ff - 2'h1;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_end;
    handler_return_op && in_handler_ff && dep_ff == 2'h0;
  endsequence
  sequence s_deep_call;
    call_op && in_handler_ff && dep_ff == 2'h3;
  endsequence

  a_one_handler: assert property (in_handler_ff && $past(in_handler_ff) |-> !jump_ff)
    else $error("start pulse while a handler runs");
  a_jump_enters: assert property (jump_ff |-> in_handler_ff ##1 in_handler_ff)
    else $error("start pulse without handler state");
  a_return_resumes: assert property (s_end |=> resume_ff && !in_handler_ff)
    else $error("return at depth zero did not resume");
  a_fourth_call_err: assert property (s_deep_call |-> ##[1:2] program_exec_error_flag)
    else $error("fourth nested call without error");
  a_error_sticky: assert property (program_exec_error_flag && !prog_load |=> program_exec_error_flag)
    else $error("error flag dropped");
  a_led_follows: assert property ($rose(program_exec_error_flag) |-> ##[0:1] err_led_ff)
    else $error("error lamp not lit");
  a_mask_clears: assert property (irq_mask_op && op_src == 3'h4 |-> ##[1:2] !periodic_irq_enabled_flag)
    else $error("periodic flag kept after mask");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule

bind psch_top psch_checker u_chk (.core_clk, .resetn, .pready, .prog_load, .call_op,
  .handler_return_op, .irq_mask_op, .op_src, .jump_ff, .resume_ff, .in_handler_ff,
  .periodic_irq_enabled_flag, .program_exec_error_flag, .err_led_ff);

// *** psch_cpu_model.sv ***
/*
  Behavioural model of the user program on the CPU core.
  Assumes jump_ff is a one-cycle start pulse from the scheduler.
*/
`timescale 1ns/1ps
module psch_cpu_model #(
  parameter PC_MAIN = 16'h0a5c
)(
  input wire core_clk,
  input wire resetn,
  input wire jump_ff,
  input wire [31:0] hold,
  input wire [31:0] calls,
  output wire [15:0] cpu_pc,
  output reg call_op,
  output reg handler_return_op
);
  reg busy_ff;
  reg [31:0] cnt_ff, ncall_ff, nret_ff;
  // Inside a handler the address is foreign, so a late sample of it is caught.
  assign cpu_pc = busy_ff ? ~PC_MAIN : PC_MAIN;
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      busy_ff <= 1'b0;
      call_op <= 1'b0;
      handler_return_op <= 1'b0;
      cnt_ff <= 0;
      ncall_ff <= 0;
      nret_ff <= 0;
    end
    else
    begin
      call_op <= 1'b0;
      handler_return_op <= 1'b0;
      if (jump_ff)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= hold;
        ncall_ff <= calls;
        nret_ff <= (calls > 3 ? 3 : calls) + 1;
      end
      else if (busy_ff && cnt_ff != 0)
        cnt_ff <= cnt_ff - 1;
      else if (busy_ff && !call_op && !handler_return_op && ncall_ff != 0)
      begin
        call_op <= 1'b1;
        ncall_ff <= ncall_ff - 1;
      end
      else if (busy_ff && !call_op && !handler_return_op)
      begin
        handler_return_op <= 1'b1;
        nret_ff <= nret_ff - 1;
        busy_ff <= nret_ff != 1;
      end
    end
endmodule

// *** tb_periodic_interrupt_scheduler.sv ***
/*
  Self-checking bench for psch_top with the CPU model.
  Assumes the shortened timing parameters set at the instance.
*/
`timescale 1ns/1ps
`include "psch_defines.vh"
module tb_periodic_interrupt_scheduler;
  reg core_clk, resetn, psel, penable, pwrite, prog_load, irq_mask_op, irq_unmask_op;
  reg cpu_running;
  reg [2:0] op_src;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg [3:0] ext_irq_line;
  reg perr;
  wire [31:0] prdata;
  wire [15:0] cpu_pc, jump_label_ff, resume_addr_ff;
  wire pready, pslverr, call_op, handler_return_op, jump_ff, resume_ff, in_handler_ff, irq;
  wire periodic_irq_enabled_flag, program_exec_error_flag, err_led_ff;
  integer hold, calls, err_total, tests_run, cyc, i, n, nj, k, v;

  psch_top #(.MS_CYCLES(20), .LAT_CYCLES(4), .RUN_MAX_CYCLES(50)) DUT (
    .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_irq_line, .cpu_running, .prog_load, .cpu_pc,
    .irq_mask_op, .irq_unmask_op, .op_src, .call_op, .handler_return_op,
    .jump_ff, .jump_label_ff, .resume_ff, .resume_addr_ff, .in_handler_ff,
    .periodic_irq_enabled_flag, .program_exec_error_flag, .err_led_ff, .irq);
  psch_cpu_model #(.PC_MAIN(16'h0a5c)) u_cpu (.core_clk, .resetn, .jump_ff, .hold,
    .calls, .cpu_pc, .call_op, .handler_return_op);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // A hang in any wait ends here rather than running forever.
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  always @(negedge core_clk)
  begin
    if (jump_ff === 1'b1)
      nj = nj + 1;
    if (resume_ff === 1'b1)
      chk(resume_addr_ff, 16'h0a5c);
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  task load;
  begin
    prog_load <= 1'b1;
    @(posedge core_clk);
    prog_load <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  task op(input m, input [2:0] s);
  begin
    irq_mask_op <= m;
    irq_unmask_op <= !m;
    op_src <= s;
    @(posedge core_clk);
    irq_mask_op <= 1'b0;
    irq_unmask_op <= 1'b0;
    repeat (2) @(posedge core_clk);
  end
  endtask
  task wj(input [15:0] exp);
  begin
    n = 0;
    @(posedge core_clk);
    while (jump_ff !== 1'b1 && n < 4000)
    begin
      n = n + 1;
      @(posedge core_clk);
    end
    chk(jump_label_ff, exp);
  end
  endtask
  task hw;
  begin
    n = 0;
    while (in_handler_ff !== 1'b0 && n < 4000)
    begin
      n = n + 1;
      @(posedge core_clk);
    end
    @(posedge core_clk);
  end
  endtask
  task firea(input integer c, input integer h);
  begin
    calls <= c;
    hold <= h;
    ext_irq_line <= 4'h0;
    repeat (5) @(posedge core_clk);
    ext_irq_line <= 4'h1;
    wj(16'h100);
    hw;
  end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
  begin
    apb(0, `PSCH_REG_CTRL, 0);
    chk(rd, 32'h00000a00);
    apb(0, `PSCH_REG_STATE, 0);
    chk(rd[4:0], 5'h1f);
    apb(0, 8'h40, 0);
    chk(perr, 1'b1);
    for (i = 0; i < 5; i = i + 1)
      apb(1, 8'(`PSCH_REG_VEC0 + 4 * i), 32'h100 + i);
    apb(0, `PSCH_REG_VEC4, 0);
    chk(rd, 32'h104);
  end
  endtask
  task t_edges;
  begin
    apb(1, `PSCH_REG_EDGE, 32'h79);
    load;
    ext_irq_line <= 4'h1;
    wj(16'h100);
    chk(n > 4 && n < 20, 1);
    hw;
    apb(1, `PSCH_REG_IMASK, 2);
    repeat (2) @(posedge core_clk);
    chk(irq, 1);
    apb(1, `PSCH_REG_ISTAT, 2);
    repeat (2) @(posedge core_clk);
    chk(irq, 0);
    apb(1, `PSCH_REG_IMASK, 0);
    k = nj;
    ext_irq_line <= 4'h3;
    repeat (40) @(posedge core_clk);
    chk(nj, k);
    cpu_running <= 1'b0;
    ext_irq_line <= 4'h1;
    repeat (40) @(posedge core_clk);
    chk(nj, k);
    cpu_running <= 1'b1;
    ext_irq_line <= 4'h3;
    repeat (10) @(posedge core_clk);
    ext_irq_line <= 4'h1;
    wj(16'h101);
    hw;
    ext_irq_line <= 4'h5;
    wj(16'h102);
    hw;
    ext_irq_line <= 4'h1;
    wj(16'h102);
    hw;
  end
  endtask
  task t_nest;
  begin
    firea(3, 60);
    chk(program_exec_error_flag, 0);
    firea(4, 2);
    chk(program_exec_error_flag, 1);
    chk(err_led_ff, 1);
    load;
    chk(program_exec_error_flag, 0);
    calls <= 0;
  end
  endtask
  task t_prio;
  begin
    ext_irq_line <= 4'h0;
    apb(1, `PSCH_REG_EDGE, 32'h55);
    apb(1, `PSCH_REG_CTRL, 32'h0a01);
    load;
    hold <= 250;
    ext_irq_line <= 4'h1;
    wj(16'h100);
    hold <= 2;
    ext_irq_line <= 4'hd;
    wj(16'h102);
    wj(16'h104);
    wj(16'h103);
    hw;
  end
  endtask
  task t_intv;
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      v = i == 0 ? 5 : i == 1 ? 140 : 200;
      apb(1, `PSCH_REG_CTRL, 32'h1 | (v << 8));
      load;
      hold <= 30;
      wj(16'h104);
      wj(16'h104);
      chk(n + 1, (v < 10 ? 10 : v > 140 ? 140 : v) * 20);
    end
  end
  endtask
  task t_mask;
  begin
    apb(1, `PSCH_REG_CTRL, 32'h0a01);
    load;
    hold <= 2;
    wj(16'h104);
    hw;
    chk(periodic_irq_enabled_flag, 1);
    op(1, 3'h4);
    chk(periodic_irq_enabled_flag, 0);
    k = nj;
    repeat (450) @(posedge core_clk);
    chk(nj, k);
    op(0, 3'h4);
    chk(periodic_irq_enabled_flag, 1);
    hold <= 60;
    wj(16'h104);
    hw;
    chk(program_exec_error_flag, 1);
  end
  endtask

  task print_verdict;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  initial
  begin
    {resetn, psel, penable, pwrite, prog_load, irq_mask_op, irq_unmask_op} = 7'h0;
    cpu_running = 1'b1;
    {op_src, paddr, pwdata, ext_irq_line} = 0;
    {hold, calls, err_total, tests_run, cyc, nj} = 0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_edges;
    t_nest;
    t_prio;
    t_intv;
    t_mask;
    print_verdict;
  end
endmodule
